// [rtl/pmtb_pkg.sv]
// Purpose: Constants shared by the PWM master time base block.
// Assumes: APB with 32-bit data, one register per aligned word.
// Notes:   Offsets are byte addresses.
package pmtb_pkg;
    // ========================================
    // Register offsets
    localparam logic [7:0] OFS_PCON   = 8'h00;
    localparam logic [7:0] OFS_PPER   = 8'h04;
    localparam logic [7:0] OFS_PCMP   = 8'h08;
    localparam logic [7:0] OFS_PTMR   = 8'h0C;
    localparam logic [7:0] OFS_SCON   = 8'h10;
    localparam logic [7:0] OFS_SPER   = 8'h14;
    localparam logic [7:0] OFS_SCMP   = 8'h18;
    localparam logic [7:0] OFS_STMR   = 8'h1C;
    localparam logic [7:0] OFS_IFLAG  = 8'h20;
    // ========================================
    // Field positions
    localparam int BIT_EN      = 15;
    localparam int BIT_PEND    = 12;
    localparam int BIT_IEN     = 11;
    localparam int BIT_PFLAG   = 11;
    localparam int BIT_SFLAG   = 12;
    localparam int DIV_LO      = 4;
    localparam int DIV_HI      = 6;
    localparam int PS_LO       = 0;
    localparam int PS_HI       = 3;
    // ========================================
    // Reset values and limits
    localparam logic [15:0] PER_RESET = 16'h0020;
    localparam logic [15:0] PER_MIN   = 16'h0008;
    localparam logic [15:0] ZERO16    = 16'h0000;
    localparam logic [31:0] ZERO32    = 32'h0000_0000;
endpackage

// [rtl/pmtb_tick_if.sv]
// Purpose: Carries a time base's settings and its events.
// Assumes: One clock domain.
// Notes:   Control side drives settings, time base drives results.
`timescale 1ns/1ps
interface pmtb_tick_if;
    logic        run;
    logic [2:0]  div;
    logic [3:0]  post;
    logic [15:0] period;
    logic [15:0] compare;
    logic [15:0] count;
    logic        trigger;
    modport ctl  (output run, div, post, period, compare, input count, trigger);
    modport base (input run, div, post, period, compare, output count, trigger);
endinterface

// [rtl/pmtb_time_base.sv]
// Purpose: One 16-bit time base with prescaler, compare and postscaler.
// Assumes: Settings change only while stopped.
// Notes:   Trigger is a one-cycle pulse.
`timescale 1ns/1ps
module pmtb_time_base
    import pmtb_pkg::*;
(
    input  wire logic   mclk, // System clock.
    input  wire logic   rst,  // Asynchronous reset, active high.
    pmtb_tick_if.base   tb    // Settings in, count and trigger out.
);
    logic [6:0]  preCnt_r;
    logic [3:0]  postCnt_r;
    logic [15:0] count_r;
    logic        trig_r;
    logic        tick;
    logic [15:0] effPer;
    logic        match;

    // ========================================
    // Prescaler and period clamp
    assign tick   = (preCnt_r == 7'((8'h01 << tb.div) - 8'h01));
    assign effPer = (tb.period < PER_MIN) ? PER_MIN : tb.period;
    assign match  = tick && (count_r == tb.compare);
    assign tb.count   = count_r;
    assign tb.trigger = trig_r;

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            preCnt_r <= 7'h00;
        else if (!tb.run || tick)
            preCnt_r <= 7'h00;
        else
            preCnt_r <= preCnt_r + 7'h01;
    end

    // ========================================
    // Counter
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            count_r <= ZERO16;
        else if (!tb.run)
            count_r <= ZERO16;
        else if (tick && count_r >= effPer)
            count_r <= ZERO16;
        else if (tick)
            count_r <= count_r + 16'h0001;
    end

    // ========================================
    // Postscaler
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            postCnt_r <= 4'h0;
            trig_r    <= 1'b0;
        end
        else if (!tb.run)
        begin
            postCnt_r <= 4'h0;
            trig_r    <= 1'b0;
        end
        else
        begin
            trig_r <= match && (postCnt_r >= tb.post);
            if (match)
                postCnt_r <= (postCnt_r >= tb.post) ? 4'h0 : postCnt_r + 4'h1;
        end
    end
endmodule // pmtb_time_base

// [rtl/pmtb_top.sv]
// Purpose: Primary and secondary PWM master time bases with APB registers.
// Assumes: APB master keeps the request steady through the access phase.
// Notes:   Zero wait states; every APB transfer completes in its access cycle.
//
// How it works
// - Pending clears after enable and flag cleared
// - Flag clear ignored while enable is one
// - Period is 16 bits, resets to 0x20
// - Period below eight runs as eight
// - Compare is 16-bit read/write, resets zero
// - Primary timer read-only, counts to period
// - Secondary pending bit 12, hardware only
// - Secondary interrupt enable at bit 11
// - Secondary prescaler divides by two to field
// - Secondary postscaler ratio is field plus one
// - Unimplemented bits read as zero
// - Module enable at primary control bit 15
// - Primary prescaler divides by two to field
// - Primary trigger every field-plus-one matches
// - Secondary timer counts like the primary
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
module pmtb_top
    import pmtb_pkg::*;
(
    input  wire logic        mclk,         // System clock, 50 MHz.
    input  wire logic        rst,          // Asynchronous reset, active high.
    input  wire logic        psel,         // APB select.
    input  wire logic        penable,      // APB access phase.
    input  wire logic        pwrite,       // APB write.
    input  wire logic [7:0]  paddr,        // APB byte address.
    input  wire logic [31:0] pwdata,       // APB write data.
    output logic      [31:0] prdata,       // APB read data.
    output logic             pready,       // APB ready.
    output logic             pslverr,      // APB error for unmapped address.
    output logic             primaryTrig,  // Primary trigger pulse to converter.
    output logic             secondaryTrig,// Secondary trigger pulse to converter.
    output logic             primaryIrq,   // Primary interrupt flag level.
    output logic             secondaryIrq  // Secondary interrupt flag level.
);
    pmtb_tick_if pri ();
    pmtb_tick_if sec ();

    logic        enable_r;
    logic        pIen_r;
    logic        pPend_r;
    logic [2:0]  pDiv_r;
    logic [3:0]  pPost_r;
    logic [15:0] pPer_r;
    logic [15:0] pCmp_r;
    logic        sIen_r;
    logic        sPend_r;
    logic [2:0]  sDiv_r;
    logic [3:0]  sPost_r;
    logic [15:0] sPer_r;
    logic [15:0] sCmp_r;
    logic        pFlag_r;
    logic        sFlag_r;
    logic        pTrig_r;
    logic        sTrig_r;
    logic        wrEn;
    logic        rdEn;
    logic        mapped;
    logic [31:0] rdMux;
    logic        wrPCon;
    logic        wrSCon;
    logic        wrPPer;
    logic        wrPCmp;
    logic        wrSPer;
    logic        wrSCmp;
    logic        wrFlag;

    // ========================================
    // Time bases
    assign pri.run     = enable_r;
    assign pri.div     = pDiv_r;
    assign pri.post    = pPost_r;
    assign pri.period  = pPer_r;
    assign pri.compare = pCmp_r;
    assign sec.run     = enable_r;
    assign sec.div     = sDiv_r;
    assign sec.post    = sPost_r;
    assign sec.period  = sPer_r;
    assign sec.compare = sCmp_r;

    pmtb_time_base uPrimary
    (
        .mclk (mclk),
        .rst  (rst),
        .tb   (pri.base)
    );

    pmtb_time_base uSecondary
    (
        .mclk (mclk),
        .rst  (rst),
        .tb   (sec.base)
    );

    // ========================================
    // APB decode
    assign wrEn    = psel && penable && pwrite;
    assign rdEn    = psel && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // ========================================
    // Write strobes, one per writable register; the timer registers have none.
    assign wrPCon = wrEn && (paddr == OFS_PCON);
    assign wrSCon = wrEn && (paddr == OFS_SCON);
    assign wrPPer = wrEn && (paddr == OFS_PPER);
    assign wrPCmp = wrEn && (paddr == OFS_PCMP);
    assign wrSPer = wrEn && (paddr == OFS_SPER);
    assign wrSCmp = wrEn && (paddr == OFS_SCMP);
    assign wrFlag = wrEn && (paddr == OFS_IFLAG);

    always_comb
    begin
        mapped = 1'b1;
        rdMux  = ZERO32;
        case (paddr)
            OFS_PCON:
            begin
                rdMux[BIT_EN]          = enable_r;
                rdMux[BIT_PEND]        = pPend_r;
                rdMux[BIT_IEN]         = pIen_r;
                rdMux[DIV_HI:DIV_LO]   = pDiv_r;
                rdMux[PS_HI:PS_LO]     = pPost_r;
            end
            OFS_PPER:  rdMux[15:0] = pPer_r;
            OFS_PCMP:  rdMux[15:0] = pCmp_r;
            OFS_PTMR:  rdMux[15:0] = pri.count;
            OFS_SCON:
            begin
                rdMux[BIT_PEND]        = sPend_r;
                rdMux[BIT_IEN]         = sIen_r;
                rdMux[DIV_HI:DIV_LO]   = sDiv_r;
                rdMux[PS_HI:PS_LO]     = sPost_r;
            end
            OFS_SPER:  rdMux[15:0] = sPer_r;
            OFS_SCMP:  rdMux[15:0] = sCmp_r;
            OFS_STMR:  rdMux[15:0] = sec.count;
            OFS_IFLAG:
            begin
                rdMux[BIT_PFLAG] = pFlag_r;
                rdMux[BIT_SFLAG] = sFlag_r;
            end
            default:   mapped = 1'b0;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            prdata <= ZERO32;
        else if (rdEn && !penable)
            prdata <= rdMux;
    end

    // ========================================
    // Primary control register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            enable_r <= 1'b0;
            pIen_r   <= 1'b0;
            pDiv_r   <= 3'h0;
            pPost_r  <= 4'h0;
        end
        else if (wrPCon)
        begin
            enable_r <= pwdata[BIT_EN];
            pIen_r   <= pwdata[BIT_IEN];
            pDiv_r   <= pwdata[DIV_HI:DIV_LO];
            pPost_r  <= pwdata[PS_HI:PS_LO];
        end
    end

    // ========================================
    // Secondary control register
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sIen_r  <= 1'b0;
            sDiv_r  <= 3'h0;
            sPost_r <= 4'h0;
        end
        else if (wrSCon)
        begin
            sIen_r  <= pwdata[BIT_IEN];
            sDiv_r  <= pwdata[DIV_HI:DIV_LO];
            sPost_r <= pwdata[PS_HI:PS_LO];
        end
    end

    // ========================================
    // Period and compare registers
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pPer_r <= PER_RESET;
        end
        else if (wrPPer)
        begin
            pPer_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pCmp_r <= ZERO16;
        end
        else if (wrPCmp)
        begin
            pCmp_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sPer_r <= PER_RESET;
        end
        else if (wrSPer)
        begin
            sPer_r <= pwdata[15:0];
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sCmp_r <= ZERO16;
        end
        else if (wrSCmp)
        begin
            sCmp_r <= pwdata[15:0];
        end
    end

    // ========================================
    // Interrupt flags: set wins, clear only with enable low.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pFlag_r <= 1'b0;
        end
        else if (pri.trigger)
        begin
            pFlag_r <= 1'b1;
        end
        else if (wrFlag && !pwdata[BIT_PFLAG] && !pIen_r)
        begin
            pFlag_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sFlag_r <= 1'b0;
        end
        else if (sec.trigger)
        begin
            sFlag_r <= 1'b1;
        end
        else if (wrFlag && !pwdata[BIT_SFLAG] && !sIen_r)
        begin
            sFlag_r <= 1'b0;
        end
    end

    // ========================================
    // Pending status: clears once enable and flag are both low.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pPend_r <= 1'b0;
        end
        else if (pri.trigger)
        begin
            pPend_r <= 1'b1;
        end
        else if (!pIen_r && !pFlag_r)
        begin
            pPend_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sPend_r <= 1'b0;
        end
        else if (sec.trigger)
        begin
            sPend_r <= 1'b1;
        end
        else if (!sIen_r && !sFlag_r)
        begin
            sPend_r <= 1'b0;
        end
    end

    // ========================================
    // Trigger outputs
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pTrig_r <= 1'b0;
        end
        else
        begin
            pTrig_r <= pri.trigger;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sTrig_r <= 1'b0;
        end
        else
        begin
            sTrig_r <= sec.trigger;
        end
    end

    // ========================================
    // Output drive
    assign primaryTrig   = pTrig_r;
    assign secondaryTrig = sTrig_r;
    assign primaryIrq    = pFlag_r;
    assign secondaryIrq  = sFlag_r;
endmodule // pmtb_top

// [bench/pmtb_checker.sv]
// Purpose: Port assertions for the PWM master time base block.
// Assumes: One clock domain, reset active high.
// Notes:   Bound to the top module below.
`timescale 1ns/1ps
module pmtb_checker
    import pmtb_pkg::*;
(
    input wire logic        mclk,          // Clock.
    input wire logic        rst,           // Reset.
    input wire logic        psel,          // Select.
    input wire logic        penable,       // Access.
    input wire logic        pwrite,        // Write.
    input wire logic [7:0]  paddr,         // Address.
    input wire logic [31:0] pwdata,        // Write data.
    input wire logic [31:0] prdata,        // Read data.
    input wire logic        pready,        // Ready.
    input wire logic        pslverr,       // Error.
    input wire logic        primaryTrig,   // Primary trigger.
    input wire logic        secondaryTrig, // Secondary trigger.
    input wire logic        primaryIrq,    // Primary flag.
    input wire logic        secondaryIrq   // Secondary flag.
);
    // ====================
    // Sequences
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic flagWr;
    assign flagWr = psel && penable && pwrite && paddr == OFS_IFLAG;
    sequence s_read;
        psel && penable && pready && !pwrite;
    endsequence
    sequence s_pquiet;
        !primaryTrig [*8];
    endsequence
    sequence s_squiet;
        !secondaryTrig [*8];
    endsequence
    // ====================
    // Assertions
    a_read_upper_zero: assert property (s_read |-> prdata[31:16] == ZERO16)
        else $error("upper read bits not zero");
    a_unmapped_err: assert property (psel && penable && paddr > OFS_IFLAG |-> pslverr)
        else $error("unmapped access without error");
    a_ptrig_gap: assert property (primaryTrig |=> s_pquiet)
        else $error("primary triggers too close");
    a_strig_gap: assert property (secondaryTrig |=> s_squiet)
        else $error("secondary triggers too close");
    a_pirq_on_trig: assert property (primaryTrig |-> primaryIrq)
        else $error("primary flag missing at trigger");
    a_pirq_rise: assert property ($rose(primaryIrq) |-> primaryTrig)
        else $error("primary flag rose without trigger");
    a_sirq_rise: assert property ($rose(secondaryIrq) |-> secondaryTrig)
        else $error("secondary flag rose without trigger");
    a_pirq_fall: assert property (!(flagWr && !pwdata[BIT_PFLAG]) |=> !$fell(primaryIrq))
        else $error("primary flag fell without clear");
    a_sirq_fall: assert property (!(flagWr && !pwdata[BIT_SFLAG]) |=> !$fell(secondaryIrq))
        else $error("secondary flag fell without clear");
endmodule // pmtb_checker

bind pmtb_top pmtb_checker u_chk (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .primaryTrig(primaryTrig), .secondaryTrig(secondaryTrig),
    .primaryIrq(primaryIrq), .secondaryIrq(secondaryIrq));

// [bench/pmtb_event_sink.sv]
// Purpose: Converter trigger input standing at the far side.
// Assumes: Triggers are one-cycle pulses.
// Notes:   Keeps a pulse count and the cycle gap of the last two.
`timescale 1ns/1ps
module pmtb_event_sink
(
    input  wire logic mclk,   // Clock.
    input  wire logic rst,    // Reset.
    input  wire logic trig,   // Trigger pulse.
    output int        pulses, // Pulses seen.
    output int        gap     // Last gap in cycles.
);
    int now;
    int last;
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            now    <= 0;
            last   <= 0;
            pulses <= 0;
            gap    <= 0;
        end
        else
        begin
            now <= now + 1;
            if (trig)
            begin
                gap    <= now - last;
                last   <= now;
                pulses <= pulses + 1;
            end
        end
    end
endmodule // pmtb_event_sink

// [bench/testbench.sv]
// Purpose: Self-checking bench for the PWM master time base block.
// Assumes: Zero wait APB slave, 50 MHz clock.
// Notes:   Random settings from a fixed seed.
`timescale 1ns/1ps
module testbench
    import pmtb_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, v;
    logic        pready, pslverr, err, primaryTrig, secondaryTrig, primaryIrq, secondaryIrq;
    int          errTotal = 0, comparisons = 0, cyc = 0;
    int          pPulses, sPulses, pGap, sGap, i, c, p, d, k, sd, cp, n0, s0;
    localparam logic [7:0] ADR [9] = '{OFS_PCON, OFS_PPER, OFS_PCMP, OFS_PTMR, OFS_SCON,
        OFS_SPER, OFS_SCMP, OFS_STMR, OFS_IFLAG};

    pmtb_top u_dut (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .primaryTrig(primaryTrig), .secondaryTrig(secondaryTrig), .primaryIrq(primaryIrq),
        .secondaryIrq(secondaryIrq));
    pmtb_event_sink u_psink (.mclk(mclk), .rst(rst), .trig(primaryTrig), .pulses(pPulses),
        .gap(pGap));
    pmtb_event_sink u_ssink (.mclk(mclk), .rst(rst), .trig(secondaryTrig), .pulses(sPulses),
        .gap(sGap));

    initial forever #10 mclk = ~mclk;

    // ====================
    // Tasks
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("wrong value %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= dat;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, ZERO32);
        chk(n, rd, exp);
    endtask
    function automatic int gapOf(input int per, input int dv, input int ps);
        return (((per < 8) ? 8 : per) + 1) * (1 << dv) * (ps + 1);
    endfunction
    task automatic endOfTest();
        $display("comparisons %0d mismatches %0d", comparisons, errTotal);
        if (errTotal == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            errTotal++;
            endOfTest();
        end
    end

    // ====================
    // Main sequence
    initial
    begin
        void'($urandom(49));
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        for (i = 0; i < 9; i++)
            rchk("reset value", ADR[i], (i == 1 || i == 5) ? {ZERO16, PER_RESET} : ZERO32);
        apb(1'b0, 8'h24, ZERO32);
        chk("unmapped error", {31'h0, err}, 32'h0000_0001);
        chk("unmapped data", rd, ZERO32);
        for (i = 1; i < 7; i++)
            if (i != 3 && i != 4)
            begin
                v = $urandom;
                apb(1'b1, ADR[i], v);
                rchk("read back", ADR[i], {ZERO16, v[15:0]});
            end
        apb(1'b1, OFS_PTMR, 32'hFFFF_FFFF);
        rchk("timer read only", OFS_PTMR, ZERO32);
        apb(1'b1, OFS_SCON, 32'hFFFF_FFFF);
        rchk("secondary control", OFS_SCON, 32'h0000_087F);
        $display("test registers done");
        for (c = 0; c < 8; c++)
        begin
            p = (c == 0) ? 0 : (c == 1) ? 9 : (c == 2) ? 8 : $urandom_range(31);
            d = (c == 0) ? 0 : (c == 1) ? 7 : (c == 2) ? 6 : $urandom_range(4);
            k = (c == 2) ? 15 : (c < 2) ? 0 : $urandom_range(3);
            sd = (d > 0) ? d - 1 : 1;
            cp = $urandom_range(7);
            apb(1'b1, OFS_PCON, ZERO32);
            apb(1'b1, OFS_PPER, 32'(p));
            apb(1'b1, OFS_PCMP, 32'(cp));
            apb(1'b1, OFS_SPER, 32'(p + 1));
            apb(1'b1, OFS_SCMP, 32'(cp));
            apb(1'b1, OFS_SCON, 32'((sd << 4) | (k ^ 1)));
            apb(1'b1, OFS_PCON, 32'(32'h8000 | (d << 4) | k));
            n0 = pPulses;
            s0 = sPulses;
            while (pPulses < n0 + 3 || sPulses < s0 + 3)
                @(posedge mclk);
            chk("primary gap", 32'(pGap), 32'(gapOf(p, d, k)));
            chk("secondary gap", 32'(sGap), 32'(gapOf(p + 1, sd, k ^ 1)));
        end
        $display("test time base done");
        apb(1'b1, OFS_PCON, 32'h0000_0800);
        apb(1'b1, OFS_SCON, 32'h0000_0800);
        rchk("stopped timer", OFS_PTMR, ZERO32);
        apb(1'b1, OFS_IFLAG, ZERO32);
        rchk("flag kept", OFS_IFLAG, 32'h0000_1800);
        rchk("pending kept", OFS_SCON, 32'h0000_1800);
        apb(1'b1, OFS_PCON, ZERO32);
        apb(1'b1, OFS_SCON, ZERO32);
        rchk("pending held", OFS_PCON, 32'h0000_1000);
        rchk("secondary pending held", OFS_SCON, 32'h0000_1000);
        apb(1'b1, OFS_IFLAG, 32'hFFFF_FFFF);
        rchk("flag after ones", OFS_IFLAG, 32'h0000_1800);
        apb(1'b1, OFS_IFLAG, ZERO32);
        rchk("flag cleared", OFS_IFLAG, ZERO32);
        rchk("pending cleared", OFS_PCON, ZERO32);
        rchk("secondary pending cleared", OFS_SCON, ZERO32);
        chk("flag lines", {30'h0, primaryIrq, secondaryIrq}, ZERO32);
        $display("test interrupt done");
        endOfTest();
    end
endmodule // testbench
